// file: rtl/stx_serial_in.sv
`timescale 1ns/100ps
module stx_serial_in
    import stx_pkg::*;
#(
    parameter int FIFO_DEPTH = STX_FIFO_DEPTH
) (
    input  wire logic        mclk,       // System clock, 100 MHz.
    input  wire logic        rst,        // Asynchronous reset, active high.
    input  wire stx_fmt_t    fmt_sel,    // Framing select, static while running.
    input  wire stx_wid_t    wid_sel,    // Word width select, static while running.
    input  wire logic        ser_clk,    // Serial bit clock pin.
    input  wire logic        ser_fs,     // Frame sync pin.
    input  wire logic        ser_data,   // Serial data pin.
    output stx_sample_t      smp_data,   // Sample to the encoder.
    output logic             smp_valid,  // Sample present.
    input  wire logic        smp_ready,  // Encoder takes the sample.
    output logic             ovf_flag    // Sticky: a word was dropped, FIFO full.
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic       clk_d_r;
    stx_fmt_t   fmt_r;
    stx_wid_t   wid_r;

    // The clock stages reset to the idle high level of the bit clock, so a
    // release of reset can never look like a rising edge.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_r    <= 3'h4;
            s2_r    <= 3'h4;
            clk_d_r <= 1'b1;
            fmt_r   <= STX_FMT_RST;
            wid_r   <= STX_WID_RST;
        end else begin
            s1_r    <= {ser_clk, ser_fs, ser_data};
            s2_r    <= s1_r;
            clk_d_r <= s2_r[2];
            // The spare code is folded onto I2S here so that delay and channel agree.
            fmt_r   <= (fmt_sel == STX_FMT_LJ || fmt_sel == STX_FMT_RJ) ? fmt_sel : STX_FMT_I2S;
            wid_r   <= wid_sel;
        end
    end

    logic rise;
    logic fs_s;
    logic dat_s;
    assign rise  = s2_r[2] && !clk_d_r;
    assign fs_s  = s2_r[1];
    assign dat_s = s2_r[0];

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] width_of(input stx_wid_t w);
        case (w)
            STX_W16: width_of = 6'h10;
            STX_W18: width_of = 6'h12;
            STX_W20: width_of = 6'h14;
            default: width_of = 6'h18;
        endcase
    endfunction : width_of

    // Bit clocks from the sync edge to the MSB.
    function automatic logic [5:0] msb_delay(input stx_fmt_t f, input stx_wid_t w);
        case (f)
            STX_FMT_I2S: msb_delay = STX_I2S_DELAY;
            STX_FMT_LJ:  msb_delay = STX_LJ_DELAY;
            STX_FMT_RJ:  msb_delay = STX_RJ_FRAME - width_of(w);
            default:     msb_delay = STX_I2S_DELAY;
        endcase
    endfunction : msb_delay

    // ----------------------------------------------------------------
    // Bit capture
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SYNC,
        ST_WAIT,
        ST_SHIFT,
        ST_DONE
    } stx_state_t;

    stx_state_t          st_r;
    stx_state_t          st_nxt;
    logic [5:0]          cnt_r;
    logic [5:0]          cnt_nxt;
    logic [STX_MAXW-1:0] sh_r;
    logic [STX_MAXW-1:0] sh_nxt;
    logic                fs_p_r;
    logic                fs_p_nxt;
    logic                chr_r;
    logic                chr_nxt;
    logic                push;
    stx_sample_t         push_data;
    logic [5:0]          wbits;
    logic [5:0]          dly;

    always_comb begin
        wbits     = width_of(wid_r);
        dly       = msb_delay(fmt_r, wid_r);
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        fs_p_nxt  = fs_p_r;
        chr_nxt   = chr_r;
        push      = 1'b0;
        push_data = '{is_right: chr_r, word: sh_r};
        if (rise) begin
            fs_p_nxt = fs_s;
            if (fs_s != fs_p_r) begin
                // Channel from the new sync level: I2S uses low for left.
                chr_nxt = (fmt_r == STX_FMT_I2S) ? fs_s : !fs_s;
                sh_nxt  = '0;
                if (dly == 6'h00) begin
                    sh_nxt  = {{(STX_MAXW-1){1'b0}}, dat_s};
                    cnt_nxt = 6'h01;
                    st_nxt  = ST_SHIFT;
                end else begin
                    cnt_nxt = dly - 6'h01;
                    st_nxt  = (dly == 6'h01) ? ST_SHIFT : ST_WAIT;
                    if (dly == 6'h01) begin
                        cnt_nxt = 6'h00;
                    end
                end
            end else begin
                case (st_r)
                    ST_WAIT: begin
                        cnt_nxt = cnt_r - 6'h01;
                        if (cnt_r == 6'h01) begin
                            cnt_nxt = 6'h00;
                            st_nxt  = ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        sh_nxt  = {sh_r[STX_MAXW-2:0], dat_s};
                        cnt_nxt = cnt_r + 6'h01;
                    end
                    default: begin
                        // Bits past the word width are ignored.
                    end
                endcase
            end
        end
        // Hand over once the full width is in; only full words go out.
        if (st_r == ST_SHIFT && cnt_r == wbits) begin
            push    = 1'b1;
            st_nxt  = (rise && fs_s != fs_p_r) ? st_nxt : ST_DONE;
            cnt_nxt = (rise && fs_s != fs_p_r) ? cnt_nxt : 6'h00;
            sh_nxt  = (rise && fs_s != fs_p_r) ? sh_nxt : sh_r;
            push_data.word = sh_r << (6'(STX_MAXW) - wbits);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r   <= ST_SYNC;
            cnt_r  <= 6'h00;
            sh_r   <= '0;
            fs_p_r <= 1'b0;
            chr_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            fs_p_r <= fs_p_nxt;
            chr_r  <= chr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Sample buffer and registered outputs
    // ----------------------------------------------------------------
    logic        f_wready;
    logic        f_rvalid;
    stx_sample_t f_rdata;
    logic        f_take;
    logic        ov_nxt;
    stx_sample_t out_nxt;
    logic        val_nxt;

    // Outputs are a one-deep register stage so they come from flops.
    always_comb begin
        f_take  = f_rvalid && (!smp_valid || smp_ready);
        val_nxt = smp_valid && !smp_ready;
        out_nxt = smp_data;
        if (f_take) begin
            val_nxt = 1'b1;
            out_nxt = f_rdata;
        end
        ov_nxt = ovf_flag || (push && !f_wready);
    end

    stx_fifo #(
        .WIDTH (STX_SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk   (mclk),
        .rst    (rst),
        .wvalid (push),
        .wready (f_wready),
        .wdata  (push_data),
        .rvalid (f_rvalid),
        .rready (f_take),
        .rdata  (f_rdata)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            smp_valid <= 1'b0;
            smp_data  <= '0;
            ovf_flag  <= 1'b0;
        end else begin
            smp_valid <= val_nxt;
            smp_data  <= out_nxt;
            ovf_flag  <= ov_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_reset_i2s;
        @(posedge mclk) $fell(rst) |-> fmt_r == STX_FMT_I2S;
    endproperty
    property p_sample_rise;
        @(posedge mclk) disable iff (rst) (st_r == ST_SHIFT && st_nxt == ST_SHIFT && cnt_nxt != cnt_r
            && !(rise && fs_s != fs_p_r)) |-> rise;
    endproperty
    property p_push_width;
        @(posedge mclk) disable iff (rst) push |-> st_r == ST_SHIFT && (push_data.word << width_of(wid_r)) == '0;
    endproperty
    property p_i2s_chan;
        @(posedge mclk) disable iff (rst) (rise && fs_s != fs_p_r && fmt_r == STX_FMT_I2S) |=> chr_r == fs_p_r;
    endproperty
    property p_lj_chan;
        @(posedge mclk) disable iff (rst) (rise && fs_s != fs_p_r && fmt_r != STX_FMT_I2S) |=> chr_r != fs_p_r;
    endproperty
    property p_lj_nodelay;
        @(posedge mclk) disable iff (rst) (rise && fs_s != fs_p_r && fmt_r == STX_FMT_LJ) |=> st_r == ST_SHIFT
            && cnt_r == 6'h01;
    endproperty
    property p_i2s_delay;
        @(posedge mclk) disable iff (rst) (rise && fs_s != fs_p_r && fmt_r == STX_FMT_I2S) |=> st_r == ST_SHIFT
            && cnt_r == 6'h00;
    endproperty
    property p_rj_delay;
        @(posedge mclk) disable iff (rst) (rise && fs_s != fs_p_r && fmt_r == STX_FMT_RJ) |=> st_r == ST_WAIT
            && cnt_r == 6'(6'h1F - width_of(wid_r));
    endproperty
    property p_valid_hold;
        @(posedge mclk) disable iff (rst) (smp_valid && !smp_ready) |=> smp_valid && $stable(smp_data);
    endproperty

    a_reset_i2s:   assert property (p_reset_i2s)   else $error("reset framing wrong");
    a_sample_rise: assert property (p_sample_rise) else $error("bit taken off edge");
    a_push_width:  assert property (p_push_width)  else $error("word length wrong");
    a_i2s_chan:    assert property (p_i2s_chan)    else $error("i2s channel wrong");
    a_lj_chan:     assert property (p_lj_chan)     else $error("lj/rj channel wrong");
    a_lj_nodelay:  assert property (p_lj_nodelay)  else $error("lj msb delayed");
    a_i2s_delay:   assert property (p_i2s_delay)   else $error("i2s delay wrong");
    a_rj_delay:    assert property (p_rj_delay)    else $error("rj delay wrong");
    a_valid_hold:  assert property (p_valid_hold)  else $error("sample dropped");

    c_push:  cover property (@(posedge mclk) push);
    c_rj:    cover property (@(posedge mclk) push && fmt_r == STX_FMT_RJ);
    c_right: cover property (@(posedge mclk) push && push_data.is_right);
    c_full:  cover property (@(posedge mclk) !f_wready);

endmodule : stx_serial_in

// file: rtl/stx_pkg.sv
package stx_pkg;

    // ----------------------------------------------------------------
    // Framing and word width encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        STX_FMT_I2S   = 2'h0,
        STX_FMT_LJ    = 2'h1,
        STX_FMT_RJ    = 2'h2
    } stx_fmt_t;

    typedef enum logic [1:0] {
        STX_W16 = 2'h0,
        STX_W18 = 2'h1,
        STX_W20 = 2'h2,
        STX_W24 = 2'h3
    } stx_wid_t;

    // ----------------------------------------------------------------
    // Counts and reset values
    // ----------------------------------------------------------------
    localparam int       STX_MAXW        = 24;
    localparam int       STX_FIFO_DEPTH  = 8;
    localparam int       STX_SYNC_STAGES = 2;
    localparam int       STX_CNT_W       = 6;
    localparam logic [5:0] STX_I2S_DELAY = 6'h01;
    localparam logic [5:0] STX_LJ_DELAY  = 6'h00;
    localparam logic [5:0] STX_RJ_FRAME  = 6'h20;
    localparam stx_fmt_t STX_FMT_RST     = STX_FMT_I2S;
    localparam stx_wid_t STX_WID_RST     = STX_W24;

    // ----------------------------------------------------------------
    // Sample carried to the encoder
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                is_right;
        logic [STX_MAXW-1:0] word;
    } stx_sample_t;

    localparam int STX_SAMPLE_W = STX_MAXW + 1;

endpackage : stx_pkg

// file: rtl/stx_fifo.sv
`timescale 1ns/100ps
module stx_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,    // System clock.
    input  wire logic             rst,     // Asynchronous reset, active high.
    input  wire logic             wvalid,  // Write request.
    output logic                  wready,  // Room available.
    input  wire logic [WIDTH-1:0] wdata,   // Write data.
    output logic                  rvalid,  // Data available.
    input  wire logic             rready,  // Consumer takes data.
    output logic      [WIDTH-1:0] rdata    // Read data.
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_r;
    logic [AW:0]      rp_nxt;
    logic             full;
    logic             empty;

    always_comb begin
        full   = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
        empty  = (wp_r == rp_r);
        wready = !full;
        rvalid = !empty;
        rdata  = mem[rp_r[AW-1:0]];
        wp_nxt = (wvalid && !full) ? wp_r + 1'b1 : wp_r;
        rp_nxt = (rready && !empty) ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // Storage has no reset so it maps onto plain RAM.
    always_ff @(posedge mclk) begin
        if (wvalid && !full) begin
            mem[wp_r[AW-1:0]] <= wdata;
        end
    end

    property p_no_overflow;
        @(posedge mclk) disable iff (rst) full |=> wp_r == $past(wp_r);
    endproperty

    a_no_overflow: assert property (p_no_overflow) else $error("fifo pointer moved while full");

endmodule : stx_fifo

// file: dv/stx_src_model.sv
`timescale 1ns/100ps
module stx_src_model
    import stx_pkg::*;
(
    output logic ser_clk,  // Bit clock, still between transfers.
    output logic ser_fs,   // Frame sync.
    output logic ser_data  // Serial data.
);
    initial begin
        ser_clk  = 1'b1;
        ser_fs   = 1'b0;
        ser_data = 1'b0;
    end

    // -------------------------------------------------------------
    // One half-frame of 32 bit clocks
    // -------------------------------------------------------------
    // Idle bit slots carry a toggling pattern so nothing stale looks valid.
    task automatic send_half(input stx_fmt_t fmt, input stx_wid_t wid, input logic right, input logic [23:0] word);
        int w;
        int st;
        w  = (wid == STX_W24) ? 24 : 16 + 2 * int'(wid);
        st = (fmt == STX_FMT_RJ) ? 32 - w : (fmt == STX_FMT_LJ) ? 0 : 1;
        for (int i = 0; i < 32; i++) begin
            ser_clk = 1'b0;
            ser_fs  = (fmt == STX_FMT_I2S) ? right : ~right;
            if (i >= st && i - st < 24) ser_data = word[23 - (i - st)];
            else ser_data = ~ser_data;
            #80;
            ser_clk = 1'b1;
            #80;
        end
    endtask : send_half
endmodule : stx_src_model

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    import stx_pkg::*;
    logic        mclk;
    logic        rst;
    stx_fmt_t    fmt_sel;
    stx_wid_t    wid_sel;
    logic        ser_clk;
    logic        ser_fs;
    logic        ser_data;
    stx_sample_t smp_data;
    logic        smp_valid;
    logic        smp_ready;
    logic        ovf_flag;
    int          error_cnt;
    int          check_count;
    stx_sample_t exp_q[$];

    stx_serial_in #(.FIFO_DEPTH(STX_FIFO_DEPTH)) uut (
        .mclk(mclk), .rst(rst), .fmt_sel(fmt_sel), .wid_sel(wid_sel), .ser_clk(ser_clk), .ser_fs(ser_fs),
        .ser_data(ser_data), .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .ovf_flag(ovf_flag)
    );
    stx_src_model src (.ser_clk(ser_clk), .ser_fs(ser_fs), .ser_data(ser_data));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // -------------------------------------------------------------
    // Checking and closing
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Samples are judged at the edge where the encoder takes them.
    always @(posedge mclk) begin
        if (rst === 1'b0 && smp_valid === 1'b1 && smp_ready === 1'b1) begin
            if (exp_q.size() == 0) check("surplus sample", 25'h0, 25'h1);
            else check("sample", smp_data, exp_q.pop_front());
        end
    end

    // -------------------------------------------------------------
    // Shared steps
    // -------------------------------------------------------------
    task automatic apply_reset(input stx_fmt_t f, input stx_wid_t w);
        @(negedge mclk);
        rst       = 1'b1;
        fmt_sel   = f;
        wid_sel   = w;
        smp_ready = 1'b1;
        repeat (8) @(negedge mclk);
        check("valid in reset", 25'(smp_valid), 25'h0);
        check("overflow in reset", 25'(ovf_flag), 25'h0);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : apply_reset

    // Low bits past the word width are sent in I2S and LJ framing but must not appear.
    task automatic send(input stx_fmt_t f, input stx_wid_t w, input logic right, input logic [23:0] word, input logic keep);
        int n;
        n = (w == STX_W24) ? 24 : 16 + 2 * int'(w);
        if (keep) exp_q.push_back({right, word & (24'hFFFFFF << (24 - n))});
        src.send_half(f, w, right, word);
    endtask : send

    task automatic settle(input string name);
        repeat (40) @(negedge mclk);
        check(name, 25'(exp_q.size()), 25'h0);
    endtask : settle

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_default_i2s;
        apply_reset(STX_FMT_RST, STX_WID_RST);
        send(STX_FMT_RST, STX_WID_RST, 1'b1, 24'h5AC3E1, 1'b1);
        send(STX_FMT_RST, STX_WID_RST, 1'b0, 24'hA53C1E, 1'b1);
        settle("default framing words");
    endtask : t_default_i2s

    // The spare framing code must behave exactly like I2S.
    task automatic t_all_modes;
        stx_fmt_t f;
        stx_fmt_t mf;
        logic [23:0] a;
        logic [23:0] b;
        for (int fi = 0; fi < 4; fi++) begin
            for (int wi = 0; wi < 4; wi++) begin
                f  = stx_fmt_t'(fi);
                mf = (fi == 3) ? STX_FMT_I2S : f;
                a = 24'hC35A69 ^ 24'((fi * 4 + wi) << 12);
                b = 24'h96A5F1 ^ 24'((fi * 4 + wi) << 8);
                apply_reset(f, stx_wid_t'(wi));
                send(mf, stx_wid_t'(wi), mf == STX_FMT_I2S, a, 1'b1);
                send(mf, stx_wid_t'(wi), mf != STX_FMT_I2S, b, 1'b1);
                settle("framing and width words");
            end
        end
    endtask : t_all_modes

    // Nine words fit (eight in the buffer, one at the output); the tenth is lost.
    task automatic t_fifo_overflow;
        apply_reset(STX_FMT_LJ, STX_W16);
        smp_ready = 1'b0;
        for (int i = 0; i < 10; i++) begin
            if (i == 9) check("overflow before full", 25'(ovf_flag), 25'h0);
            send(STX_FMT_LJ, STX_W16, i[0], 24'h1234F0 ^ 24'(i << 16), i < 9);
        end
        repeat (40) @(negedge mclk);
        check("overflow when full", 25'(ovf_flag), 25'h1);
        check("valid held while stalled", 25'(smp_valid), 25'h1);
        smp_ready = 1'b1;
        settle("drained words");
        check("valid when empty", 25'(smp_valid), 25'h0);
        check("overflow sticky", 25'(ovf_flag), 25'h1);
    endtask : t_fifo_overflow

    initial begin
        rst         = 1'b1;
        fmt_sel     = STX_FMT_RST;
        wid_sel     = STX_WID_RST;
        smp_ready   = 1'b1;
        error_cnt   = 0;
        check_count = 0;
        t_default_i2s();
        t_all_modes();
        t_fifo_overflow();
        test_done();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
endmodule : tb
